//--- common/fspg_cfg.svh
// Constants for the flash self-program guard: address split, lock codes,
// boot sizes and operation timing.
// Assumes word addressing of program flash with 13 address bits.
`ifndef FSPG_CFG_SVH
`define FSPG_CFG_SVH
`define FSPG_ADDR_W 13
`define FSPG_HALT_START 13'h1C00
`define FSPG_BOOT_START_0 13'h1C00
`define FSPG_BOOT_START_1 13'h1E00
`define FSPG_BOOT_START_2 13'h1F00
`define FSPG_BOOT_START_3 13'h1F80
`define FSPG_LOCK_MODE1 2'h3
`define FSPG_LOCK_MODE2 2'h2
`define FSPG_LOCK_MODE3 2'h0
`define FSPG_LOCK_MODE4 2'h1
`define FSPG_LOCK_UNPROG 2'h3
`define FSPG_BLOCKED_DATA 16'hFFFF
`define FSPG_OP_TIME_NS 3200000
`define FSPG_CLK_PERIOD_NS 4
`define FSPG_OP_CYCLES (`FSPG_OP_TIME_NS / `FSPG_CLK_PERIOD_NS)
`define FSPG_CNT_W 20
`endif

//--- common/fspg_pkg.sv
// Types for the flash self-program guard.
// Assumes fspg_cfg.svh is on the include path.
`include "fspg_cfg.svh"
package fspg_pkg;
  typedef enum {FSPG_IDLE, FSPG_BUSY} fspg_state_e;
  typedef struct packed {
    fspg_state_e state;
    logic [`FSPG_CNT_W-1:0] count;
    logic enable_bit;
    logic busy_flag;
    logic stall;
    logic [1:0] app_lock;
    logic [1:0] boot_lock;
    logic [15:0] load_data;
    logic load_valid;
    logic store_refused;
  } fspg_state_s;
endpackage : fspg_pkg

//--- design/fspg_guard.sv
// Self-programming guard: decides store/load access, stalls the core,
// blocks fetches from the concurrent-read region and keeps busy flag.
// Assumes the core holds requests synchronous to ref_clk, single pulses.
`timescale 1ns/1ps
`include "fspg_cfg.svh"
module fspg_guard (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] boot_size_fuses,
  input wire logic [1:0] general_lock_mode,
  input wire logic chip_erase,
  input wire logic lock_write,
  input wire logic [1:0] app_lock_wdata,
  input wire logic [1:0] boot_lock_wdata,
  input wire logic [`FSPG_ADDR_W-1:0] pc_addr,
  input wire logic vectors_in_boot,
  input wire logic irq_req_in,
  input wire logic store_req,
  input wire logic [`FSPG_ADDR_W-1:0] store_addr,
  input wire logic region_read_enable,
  input wire logic load_req,
  input wire logic [`FSPG_ADDR_W-1:0] load_addr,
  input wire logic [15:0] flash_rdata,
  input wire logic flash_op_done,
  output logic flash_op_start,
  output logic [`FSPG_ADDR_W-1:0] flash_op_addr,
  output logic store_refused,
  output logic [15:0] load_data,
  output logic load_valid,
  output logic core_stall,
  output logic fetch_blocked,
  output logic region_busy_flag,
  output logic program_store_enable_bit,
  output logic irq_suppress,
  output logic [1:0] app_lock_mode,
  output logic [1:0] boot_lock_mode
);
  fspg_pkg::fspg_state_s st_reg;
  fspg_pkg::fspg_state_s st_next;
  logic [`FSPG_ADDR_W-1:0] boot_start;
  logic pc_in_boot;
  logic tgt_in_boot;
  logic tgt_in_halt;
  logic ld_in_boot;
  logic store_ok;
  logic load_ok;
  logic app_store_lock;
  logic boot_store_lock;
  logic app_read_lock;
  logic boot_read_lock;

  // Boundary selected by fuses; every start sits at or above halting start
  always_comb begin
    case (boot_size_fuses)
      2'h0: boot_start = `FSPG_BOOT_START_0;
      2'h1: boot_start = `FSPG_BOOT_START_1;
      2'h2: boot_start = `FSPG_BOOT_START_2;
      default: boot_start = `FSPG_BOOT_START_3;
    endcase
  end

  // Boot start never below halting start, so boot lies in halt region
  assign pc_in_boot = (pc_addr >= boot_start);
  assign tgt_in_boot = (store_addr >= boot_start);
  assign tgt_in_halt = (store_addr >= `FSPG_HALT_START);
  assign ld_in_boot = (load_addr >= boot_start);

  // General lock mode is deliberately not consulted here
  assign app_store_lock = (st_reg.app_lock == `FSPG_LOCK_MODE2) ||
    (st_reg.app_lock == `FSPG_LOCK_MODE3);
  assign boot_store_lock = (st_reg.boot_lock == `FSPG_LOCK_MODE2) ||
    (st_reg.boot_lock == `FSPG_LOCK_MODE3);
  assign app_read_lock = (st_reg.app_lock == `FSPG_LOCK_MODE3) ||
    (st_reg.app_lock == `FSPG_LOCK_MODE4);
  assign boot_read_lock = (st_reg.boot_lock == `FSPG_LOCK_MODE3) ||
    (st_reg.boot_lock == `FSPG_LOCK_MODE4);

  // Any target allowed from boot, limited only by locks
  assign store_ok = pc_in_boot &&
    (tgt_in_boot ? !boot_store_lock : !app_store_lock);

  // Mode 1 has neither lock term set, so only the busy term can block a load
  assign load_ok = (ld_in_boot ? !(boot_read_lock && !pc_in_boot)
    : !(app_read_lock && pc_in_boot))
    && !(st_reg.busy_flag && !ld_in_boot && load_addr < `FSPG_HALT_START);

  always_comb begin
    st_next = st_reg;
    st_next.load_valid = 1'b0;
    st_next.store_refused = 1'b0;
    // Locks only move toward programmed; erase returns them to one
    if (chip_erase) begin
      st_next.app_lock = `FSPG_LOCK_UNPROG;
      st_next.boot_lock = `FSPG_LOCK_UNPROG;
    end else if (lock_write) begin
      st_next.app_lock = st_reg.app_lock & app_lock_wdata;
      st_next.boot_lock = st_reg.boot_lock & boot_lock_wdata;
    end
    if (load_req) begin
      st_next.load_valid = 1'b1;
      st_next.load_data = load_ok ? flash_rdata
        : `FSPG_BLOCKED_DATA;
    end
    case (st_reg.state)
      fspg_pkg::FSPG_IDLE: begin
        if (region_read_enable) begin
          st_next.busy_flag = 1'b0;
        end
        if (store_req && store_ok) begin
          st_next.state = fspg_pkg::FSPG_BUSY;
          st_next.count = '0;
          st_next.enable_bit = 1'b1;
          st_next.busy_flag = 1'b1;
          st_next.stall = tgt_in_halt;
        end else if (store_req) begin
          st_next.store_refused = 1'b1;
        end
      end
      fspg_pkg::FSPG_BUSY: begin
        st_next.count = st_reg.count + `FSPG_CNT_W'(1);
        if (flash_op_done ||
            st_reg.count == `FSPG_CNT_W'(`FSPG_OP_CYCLES - 1)) begin
          st_next.state = fspg_pkg::FSPG_IDLE;
          st_next.enable_bit = 1'b0;
          st_next.stall = 1'b0;
        end
      end
      default: st_next.state = fspg_pkg::FSPG_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg.state <= fspg_pkg::FSPG_IDLE;
      st_reg.count <= '0;
      st_reg.enable_bit <= 1'b0;
      st_reg.busy_flag <= 1'b0;
      st_reg.stall <= 1'b0;
      st_reg.app_lock <= `FSPG_LOCK_UNPROG;
      st_reg.boot_lock <= `FSPG_LOCK_UNPROG;
      st_reg.load_data <= 16'h0000;
      st_reg.load_valid <= 1'b0;
      st_reg.store_refused <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Start pulse to flash sequencer only for accepted stores
  assign flash_op_start = (st_reg.state == fspg_pkg::FSPG_IDLE) &&
    store_req && store_ok;
  assign flash_op_addr = store_addr;
  assign store_refused = st_reg.store_refused;
  assign load_data = st_reg.load_data;
  assign load_valid = st_reg.load_valid;
  assign core_stall = st_reg.stall;
  assign fetch_blocked = st_reg.busy_flag &&
    (pc_addr < `FSPG_HALT_START);
  assign region_busy_flag = st_reg.busy_flag;
  assign program_store_enable_bit = st_reg.enable_bit;
  // Vectors on the other side mask interrupts in the locked region
  assign irq_suppress = irq_req_in && (
    (vectors_in_boot && !pc_in_boot && app_read_lock) ||
    (!vectors_in_boot && pc_in_boot && boot_read_lock));
  assign app_lock_mode = st_reg.app_lock;
  assign boot_lock_mode = st_reg.boot_lock;
endmodule : fspg_guard

//--- testbench/fspg_flash_model.sv
// Flash sequencer stand-in: ends a started op after LAT cycles and
// gives an address-derived word to loads. Shares the guard's clock.
`timescale 1ns/1ps
module fspg_flash_model #(parameter int LAT = 12) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic flash_op_start,
  input wire logic [12:0] load_addr,
  output logic flash_op_done,
  output logic [15:0] flash_rdata
);
  int cnt;
  assign flash_rdata = {3'h5, load_addr};
  assign flash_op_done = (cnt == 1);
  always_ff @(posedge ref_clk) begin
    if (rst) cnt <= 0;
    else if (flash_op_start) cnt <= LAT;
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule : fspg_flash_model

//--- testbench/fspg_guard_checker.sv
// Assertions on the guard's ports: op walk, stall, busy flag, refusals.
// Bound into every fspg_guard; sees only that module's ports.
`timescale 1ns/1ps
module fspg_guard_checker (
  input wire logic ref_clk, rst, store_req, load_req, region_read_enable,
  input wire logic flash_op_start, flash_op_done, store_refused, load_valid,
  input wire logic core_stall, fetch_blocked, region_busy_flag,
  input wire logic program_store_enable_bit,
  input wire logic [1:0] boot_size_fuses,
  input wire logic [12:0] pc_addr, store_addr, load_addr,
  input wire logic [15:0] load_data
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [12:0] bs;
  assign bs = 13'h1FFF << (10 - boot_size_fuses);
  sequence s_begun;
    program_store_enable_bit && region_busy_flag;
  endsequence
  sequence s_ended;
    !program_store_enable_bit && !core_stall;
  endsequence
  a_start_walk: assert property (flash_op_start |=> s_begun)
    else $error("op start without enable");
  a_op_end: assert property (program_store_enable_bit && flash_op_done |=> s_ended)
    else $error("op end not seen");
  a_enable_hold: assert property (program_store_enable_bit && !flash_op_done
    |=> program_store_enable_bit)
    else $error("enable dropped early");
  a_halt_stall: assert property (flash_op_start && store_addr >= 13'h1C00
    |=> core_stall)
    else $error("no stall");
  a_rww_run: assert property (flash_op_start && store_addr < 13'h1C00
    |=> !core_stall)
    else $error("stall on concurrent region");
  a_app_refuse: assert property (store_req && !program_store_enable_bit &&
    pc_addr < bs |-> !flash_op_start ##1 store_refused)
    else $error("store from application ran");
  a_busy_hold: assert property (region_busy_flag && !region_read_enable
    |=> region_busy_flag)
    else $error("busy dropped");
  a_fetch_block: assert property (region_busy_flag && pc_addr < 13'h1C00
    |-> fetch_blocked)
    else $error("fetch not blocked");
  a_load_block: assert property (load_req && region_busy_flag && load_addr <
    13'h1C00 |=> load_valid && load_data == 16'hFFFF)
    else $error("blocked load leaked");
  a_reset_idle: assert property (disable iff (1'b0) rst |=> !core_stall &&
    !region_busy_flag)
    else $error("not idle after reset");
endmodule : fspg_guard_checker
bind fspg_guard fspg_guard_checker chk (.*);

//--- testbench/tb_fspg_guard.sv
// Self-checking bench for fspg_guard with flash model and checker.
// Assumes fspg_cfg.svh on the include path.
`timescale 1ns/1ps
`define CHK(n,e,s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb_fspg_guard;
  logic ref_clk = 0, rst = 1, chip_erase = 0, lock_write = 0;
  logic vectors_in_boot = 0, irq_req_in = 1, store_req = 0, load_req = 0;
  logic region_read_enable = 0;
  logic [1:0] boot_size_fuses = 0, general_lock_mode = 0, al = 3, bl = 3;
  logic [1:0] app_lock_wdata = 3, boot_lock_wdata = 3;
  logic [1:0] app_lock_mode, boot_lock_mode;
  logic [12:0] pc_addr = 0, store_addr = 0, load_addr = 0, flash_op_addr;
  logic [15:0] flash_rdata, load_data;
  logic flash_op_done, flash_op_start, store_refused, load_valid;
  logic core_stall, fetch_blocked, region_busy_flag, irq_suppress;
  logic program_store_enable_bit;
  int fails = 0, cmp_count = 0, cyc = 0;
  fspg_guard dut (.*);
  fspg_flash_model model (.*);
  initial forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cyc > 30000) begin fails++; test_done(); end
  task automatic tick(); @(posedge ref_clk); #1; endtask : tick
  function automatic logic [12:0] bnd();
    return 13'h1FFF << (10 - boot_size_fuses);
  endfunction : bnd
  task automatic ld(input logic [12:0] pa, aa, input logic bz);
    logic ok;
    ok = !((pa >= bnd() && aa < bnd() && !al[1]) || (bz && aa < 13'h1C00) ||
      (pa < bnd() && aa >= bnd() && !bl[1]));
    pc_addr = pa; load_addr = aa; load_req = 1;
    tick(); load_req = 0;
    `CHK("load", ok ? {3'h5, aa} : 16'hFFFF, load_data)
  endtask : ld
  task automatic st(input logic [12:0] pa, aa);
    logic ok;
    ok = pa >= bnd() && (aa < bnd() ? al[0] : bl[0]);
    pc_addr = pa; store_addr = aa; store_req = 1; general_lock_mode = $urandom;
    tick(); store_req = 0;
    `CHK("refused", !ok, store_refused)
    `CHK("enable", ok, program_store_enable_bit)
    if (ok) begin
      `CHK("stall", aa >= 13'h1C00, core_stall)
      if (aa < 13'h1C00) ld(pa, 13'($urandom_range(13'h1BFF)), 1);
      for (int i = 0; i < 100 && program_store_enable_bit; i++) tick();
      `CHK("ended", 1'b0, program_store_enable_bit | core_stall)
      `CHK("busy", 1'b1, region_busy_flag)
      region_read_enable = 1;
      tick(); region_read_enable = 0; tick();
      `CHK("busy_clr", 1'b0, region_busy_flag)
    end
  endtask : st
  task automatic lock(input logic [1:0] a, b);
    app_lock_wdata = a; boot_lock_wdata = b; lock_write = 1;
    tick(); lock_write = 0; al &= a; bl &= b;
    `CHK("locks", {al, bl}, {app_lock_mode, boot_lock_mode})
  endtask : lock
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  initial begin
    void'($urandom(47));
    repeat (5) tick();
    rst = 0;
    `CHK("rst", 6'h0F, {core_stall, region_busy_flag, app_lock_mode, boot_lock_mode})
    for (int f = 0; f < 4; f++) begin
      boot_size_fuses = f[1:0];
      st(bnd() - 1, 13'h1FF0);
      st(bnd(), 13'($urandom_range(13'h1BFF)));
      st(bnd(), bnd() + 13'h0002);
    end
    for (int m = 0; m < 32; m++) begin
      chip_erase = 1; tick(); chip_erase = 0; al = 3; bl = 3;
      lock(m[3:2], m[1:0]);
      lock(2'h3, 2'h3);
      st(13'h1F80, 13'($urandom_range(13'h1BFF)));
      st(13'h1F80, 13'h1FC0);
      ld(13'h1F80, 13'h0040, 0);
      ld(13'h0100, 13'h1F84, 0);
      vectors_in_boot = m[4]; #1;
      `CHK("irq_app", !al[1] && m[4], irq_suppress)
      pc_addr = 13'h1F80; #1;
      `CHK("irq_boot", !bl[1] && !m[4], irq_suppress)
    end
    test_done();
  end
endmodule : tb_fspg_guard
